// *** verilog/setr_pkg.sv ***
// Package with register map, field layout and types of the egress tagging and pacing block.
`default_nettype none
package setr_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_POLICY  = 16'h1c0c;
  localparam logic [15:0] IDX_RATE_H01 = 16'h1c0d;
  localparam logic [15:0] IDX_RATE_H23 = 16'h1c0e;
  localparam logic [15:0] IDX_RATE_P01 = 16'h1c0f;
  localparam logic [15:0] IDX_RATE_P23 = 16'h1c10;
  localparam logic [15:0] IDX_STATUS  = 16'h1c3f;
  // Per-port control group positions inside the tagging policy register.
  localparam int unsigned P0_LSB    = 0;
  localparam int unsigned P1_LSB    = 8;
  localparam int unsigned P2_LSB    = 16;
  localparam int unsigned CHTAG_BIT = 2;
  localparam int unsigned CHPRI_BIT = 3;
  localparam int unsigned CHID_BIT  = 4;
  localparam int unsigned INS_BIT   = 5;
  // Rate field layout.
  localparam int unsigned RATE_W      = 13;
  localparam int unsigned RATE_LO_LSB = 0;
  localparam int unsigned RATE_HI_LSB = 13;
  // Reset values and writable bit masks.
  localparam logic [31:0] POLICY_RST  = 32'h0000_0000;
  localparam logic [31:0] RATE_RST    = 32'h0000_0000;
  localparam logic [31:0] POLICY_MASK = 32'h003f_3f3f;
  localparam logic [31:0] RATE_MASK   = 32'h03ff_ffff;
  // Pacing time unit per byte and its length in clock cycles.
  localparam int unsigned BYTE_TIME_NS = 20;
  localparam int unsigned CLK_NS       = 10;
  localparam int unsigned UNIT_CYC     = (BYTE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0]  HOST_PORT    = 2'h0;
  localparam logic [1:0]  UNPACED_PORT = 2'h2;

  typedef enum logic [1:0] {PT_DUMB, PT_ACCESS, PT_HYBRID, PT_CPU} setr_ptype_e;
  typedef enum logic [1:0] {KIND_UNTAG, KIND_PRIO, KIND_REG, KIND_SPECIAL} setr_kind_e;
  typedef enum logic [2:0] {ACT_PASS, ACT_STRIP, ACT_INSERT, ACT_REWRITE, ACT_SPECIAL} setr_act_e;

  typedef struct packed {
    logic [1:0]  eport;
    logic [1:0]  q;
    logic [1:0]  src;
    setr_kind_e  kind;
    logic        untag;
    logic [11:0] ivid;
    logic [2:0]  ipri;
    logic [11:0] evid;
    logic [2:0]  epri;
  } setr_meta_s;

  typedef struct packed {
    setr_meta_s meta;
    logic       sop;
    logic       eop;
    logic [7:0] data;
  } setr_word_s;

  typedef struct packed {
    setr_act_e   act;
    logic        set_vid;
    logic        set_pri;
    logic [11:0] vid;
    logic [2:0]  pri;
  } setr_dec_s;
endpackage
`default_nettype wire

// *** verilog/setr_stream_if.sv ***
// Interface carrying a valid/ready word stream between the block's modules.
`timescale 1ns/1ps
`default_nettype none
interface setr_stream_if #(parameter int unsigned W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** verilog/setr_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module setr_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               srst,
  // Stream sides.
  setr_stream_if.snk              wr,
  setr_stream_if.src              rd,
  // Fill level.
  output logic [$clog2(DEPTH):0]  level
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  // Full and empty come straight from the count so back-pressure is exact.
  assign wr.ready = (cnt_reg != FULL);
  assign rd.valid = (cnt_reg != '0);
  assign rd.data  = mem[rp_reg];
  assign level    = cnt_reg;
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  // Storage is written only; no reset needed on data.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= wr.data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two.
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// *** verilog/setr_egress.sv ***
// Egress tag policy and per-queue byte pacing stage with its Avalon-MM registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE_01] Type 00: pass regular, strip host special
// [RULE_02] Type 01: strip every tag, special included
// [RULE_03] Type 10: hybrid insert, strip or rewrite
// [RULE_04] Type 11: add special tag naming source
// [RULE_05] Port 1 controls at bits 13..8
// [RULE_06] Host port controls at bits 5..0
// [RULE_07] Byte time is (value plus one) times 20ns
// [RULE_08] Two 13-bit rates per register, high queue upper
// [RULE_09] Port 1 has own four rate fields
// [RULE_10] Hybrid insert uses ingress defaults unless untagged
// [RULE_11] Hybrid rewrites VID with egress default
// [RULE_12] Hybrid rewrites priority with egress default
// [RULE_13] Change tag gates only regular tagged packets
// [RULE_14] Hold queue byte until interval elapsed
module setr_egress #(
  parameter int unsigned RATE_UNIT_CYC = setr_pkg::UNIT_CYC,
  parameter int unsigned FIFO_DEPTH    = 8
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        srst,
  // Avalon-MM register slave, byte addressed.
  input  wire logic [17:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Packet bytes from the buffer manager, sideband held for the whole packet.
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [7:0]  in_data,
  input  wire logic        in_sop,
  input  wire logic        in_eop,
  input  wire logic [1:0]  in_egress_port,
  input  wire logic [1:0]  in_queue,
  input  wire logic [1:0]  in_src_port,
  input  wire logic [1:0]  in_tag_kind,
  input  wire logic        in_untag,
  input  wire logic [11:0] in_ingr_vid,
  input  wire logic [2:0]  in_ingr_pri,
  input  wire logic [11:0] in_egr_vid,
  input  wire logic [2:0]  in_egr_pri,
  // Paced bytes and tag edit orders to the port transmit paths.
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [7:0]       out_data,
  output logic             out_sop,
  output logic             out_eop,
  output logic [1:0]       out_port,
  output logic [2:0]       out_action,
  output logic             out_set_vid,
  output logic             out_set_pri,
  output logic [11:0]      out_vid,
  output logic [2:0]       out_pri,
  output logic [1:0]       out_src_port
);
  localparam int unsigned W     = $bits(setr_pkg::setr_word_s);
  localparam int unsigned LVL_W = $clog2(FIFO_DEPTH) + 1;

  // Byte address of a register index.
  function automatic logic [17:0] reg_addr(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  // Byte-lane merge of a write into a register, reserved bits forced to zero.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r & mask;
  endfunction

  // Byte interval in cycles for a programmed rate value.
  function automatic logic [15:0] pace_cycles(input logic [12:0] rate);
    return 16'((32'(rate) + 32'd1) * RATE_UNIT_CYC);
  endfunction

  // Control group of one egress port.
  function automatic logic [5:0] port_ctl(input logic [31:0] pol, input logic [1:0] port);
    if (port == setr_pkg::HOST_PORT) begin
      return pol[setr_pkg::P0_LSB +: 6];
    end else if (port == 2'h1) begin
      return pol[setr_pkg::P1_LSB +: 6];
    end else begin
      return pol[setr_pkg::P2_LSB +: 6];
    end
  endfunction

  // Tag decision for one packet from its port's controls and its sideband.
  function automatic setr_pkg::setr_dec_s decide(input logic [5:0] ctl,
                                                 input setr_pkg::setr_meta_s m);
    setr_pkg::setr_dec_s d;
    d.act     = setr_pkg::ACT_PASS;
    d.set_vid = 1'b0;
    d.set_pri = 1'b0;
    d.vid     = m.evid;
    d.pri     = m.epri;
    case (setr_pkg::setr_ptype_e'(ctl[1:0]))
      setr_pkg::PT_DUMB: begin
        if (m.kind == setr_pkg::KIND_SPECIAL) begin // [RULE_01]
          d.act = setr_pkg::ACT_STRIP;
        end
      end
      setr_pkg::PT_ACCESS: begin
        if (m.kind != setr_pkg::KIND_UNTAG) begin // [RULE_02]
          d.act = setr_pkg::ACT_STRIP;
        end
      end
      setr_pkg::PT_CPU: begin
        d.act = setr_pkg::ACT_SPECIAL; // [RULE_04]
      end
      default: begin
        // Hybrid: the untag bit always wins over any change order. [RULE_03]
        if (m.kind == setr_pkg::KIND_UNTAG) begin
          if (ctl[setr_pkg::INS_BIT] && !m.untag) begin // [RULE_10]
            d.act     = setr_pkg::ACT_INSERT;
            d.set_vid = 1'b1;
            d.set_pri = 1'b1;
            d.vid     = m.ivid;
            d.pri     = m.ipri;
          end
        end else if (m.kind == setr_pkg::KIND_SPECIAL || m.untag) begin
          d.act = setr_pkg::ACT_STRIP;
        end else if (m.kind == setr_pkg::KIND_PRIO) begin
          // Priority tags always take the ingress VID; change tag is ignored. [RULE_13]
          d.act     = setr_pkg::ACT_REWRITE;
          d.set_vid = 1'b1;
          d.vid     = m.ivid;
          d.set_pri = ctl[setr_pkg::CHPRI_BIT];
        end else if (ctl[setr_pkg::CHTAG_BIT] &&
                     (ctl[setr_pkg::CHID_BIT] || ctl[setr_pkg::CHPRI_BIT])) begin
          d.act     = setr_pkg::ACT_REWRITE;
          d.set_vid = ctl[setr_pkg::CHID_BIT]; // [RULE_11]
          d.set_pri = ctl[setr_pkg::CHPRI_BIT]; // [RULE_12]
        end
      end
    endcase
    return d;
  endfunction

  logic [31:0]             policy_reg;
  logic [31:0]             rate_reg [4];
  logic                    ack_reg;
  logic                    req;
  logic                    wr_en;
  logic [31:0]             rd_mux;
  logic [15:0]             tmr_reg [8];
  logic [LVL_W-1:0]        level;
  setr_pkg::setr_word_s    head;
  setr_pkg::setr_dec_s     dec;
  logic [5:0]              ctl;
  logic                    paced;
  logic [2:0]              pidx;
  logic [12:0]             cur_rate;
  logic                    gate_open;
  logic                    load;
  logic                    out_valid_reg;
  setr_pkg::setr_word_s    out_word_reg;
  setr_pkg::setr_dec_s     out_dec_reg;

  setr_stream_if #(.W(W)) s_in ();
  setr_stream_if #(.W(W)) s_out ();

  // Incoming bytes are packed with their sideband and queued; the FIFO ready stalls the source.
  assign s_in.valid = in_valid;
  assign s_in.data  = {in_egress_port, in_queue, in_src_port, in_tag_kind, in_untag,
                       in_ingr_vid, in_ingr_pri, in_egr_vid, in_egr_pri, in_sop, in_eop, in_data};
  assign in_ready   = s_in.ready;

  setr_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (clk),
    .srst  (srst),
    .wr    (s_in),
    .rd    (s_out),
    .level (level)
  );

  // Head-of-line decode: controls, rate and pacing gate for the byte at the FIFO output.
  assign head     = setr_pkg::setr_word_s'(s_out.data);
  assign ctl      = port_ctl(policy_reg, head.meta.eport); // [RULE_05] [RULE_06]
  assign dec      = decide(ctl, head.meta);
  assign paced    = (head.meta.eport != setr_pkg::UNPACED_PORT);
  assign pidx     = {head.meta.eport[0], head.meta.q};
  assign cur_rate = head.meta.q[0]
                  ? rate_reg[pidx[2:1]][setr_pkg::RATE_HI_LSB +: setr_pkg::RATE_W] // [RULE_08]
                  : rate_reg[pidx[2:1]][setr_pkg::RATE_LO_LSB +: setr_pkg::RATE_W]; // [RULE_09]
  assign gate_open = !paced || (tmr_reg[pidx] == '0); // [RULE_14]
  assign load      = s_out.valid && gate_open && (!out_valid_reg || out_ready);
  assign s_out.ready = load;

  // One interval timer per paced queue; port 2 has no rate registers here and is not paced.
  always_ff @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (srst) begin
        tmr_reg[i] <= '0;
      end else if (load && paced && pidx == 3'(i)) begin
        tmr_reg[i] <= pace_cycles(cur_rate) - 16'h0001; // [RULE_07] [RULE_14]
      end else if (tmr_reg[i] != '0) begin
        tmr_reg[i] <= tmr_reg[i] - 16'h0001;
      end
    end
  end

  // Output stage holds a byte and its tag orders until the port takes it.
  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid_reg <= 1'b0;
      out_word_reg  <= '0;
      out_dec_reg   <= '0;
    end else if (load) begin
      out_valid_reg <= 1'b1;
      out_word_reg  <= head;
      out_dec_reg   <= dec;
    end else if (out_ready) begin
      out_valid_reg <= 1'b0;
    end
  end

  assign out_valid    = out_valid_reg;
  assign out_data     = out_word_reg.data;
  assign out_sop      = out_word_reg.sop;
  assign out_eop      = out_word_reg.eop;
  assign out_port     = out_word_reg.meta.eport;
  assign out_src_port = out_word_reg.meta.src;
  assign out_action   = out_dec_reg.act;
  assign out_set_vid  = out_dec_reg.set_vid;
  assign out_set_pri  = out_dec_reg.set_pri;
  assign out_vid      = out_dec_reg.vid;
  assign out_pri      = out_dec_reg.pri;

  // Bus handshake: one wait cycle, then the access completes at the next edge.
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign wr_en           = avs_write & ack_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address == reg_addr(setr_pkg::IDX_POLICY)) begin
      rd_mux = policy_reg;
    end else if (avs_address == reg_addr(setr_pkg::IDX_STATUS)) begin
      rd_mux[LVL_W-1:0] = level;
      rd_mux[8]         = out_valid_reg;
      rd_mux[9]         = s_out.valid & ~gate_open;
      for (int i = 0; i < 8; i++) begin
        rd_mux[16+i] = (tmr_reg[i] != '0);
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (avs_address == reg_addr(setr_pkg::IDX_RATE_H01 + 16'(i))) begin
          rd_mux = rate_reg[i];
        end
      end
    end
  end

  // Read data is captured in the wait cycle and stands until the next read.
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      avs_readdata <= rd_mux;
    end
  end

  // Policy register; a write lands at the edge where waitrequest is low.
  always_ff @(posedge clk) begin
    if (srst) begin
      policy_reg <= setr_pkg::POLICY_RST;
    end else if (wr_en && avs_address == reg_addr(setr_pkg::IDX_POLICY)) begin
      policy_reg <= merge(policy_reg, avs_writedata, avs_byteenable, setr_pkg::POLICY_MASK);
    end
  end

  // Rate registers for host and port 1 queues.
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (srst) begin
        rate_reg[i] <= setr_pkg::RATE_RST;
      end else if (wr_en && avs_address == reg_addr(setr_pkg::IDX_RATE_H01 + 16'(i))) begin
        rate_reg[i] <= merge(rate_reg[i], avs_writedata, avs_byteenable, setr_pkg::RATE_MASK);
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_dumb_pass: assert property ( // [RULE_01]
    load && ctl[1:0] == 2'b00 && head.meta.kind != setr_pkg::KIND_SPECIAL
    |=> out_action == 3'(setr_pkg::ACT_PASS)) else $error("dumb port altered a packet");
  a_dumb_strip: assert property ( // [RULE_01]
    load && ctl[1:0] == 2'b00 && head.meta.kind == setr_pkg::KIND_SPECIAL
    |=> out_action == 3'(setr_pkg::ACT_STRIP)) else $error("dumb port kept special tag");
  a_access_strip: assert property ( // [RULE_02]
    load && ctl[1:0] == 2'b01 && head.meta.kind != setr_pkg::KIND_UNTAG
    |=> out_action == 3'(setr_pkg::ACT_STRIP)) else $error("access port kept a tag");
  a_cpu_special: assert property (load && ctl[1:0] == 2'b11 // [RULE_04]
    |=> out_action == 3'(setr_pkg::ACT_SPECIAL) && out_src_port == $past(head.meta.src))
    else $error("cpu port missing source tag");
  a_hyb_insert: assert property ( // [RULE_10] [RULE_03]
    load && ctl[1:0] == 2'b10 && ctl[5] && !head.meta.untag
    && head.meta.kind == setr_pkg::KIND_UNTAG
    |=> out_action == 3'(setr_pkg::ACT_INSERT) && out_vid == $past(head.meta.ivid))
    else $error("hybrid insert wrong");
  a_hyb_vid: assert property ( // [RULE_11]
    load && ctl[1:0] == 2'b10 && ctl[2] && ctl[4] && !head.meta.untag
    && head.meta.kind == setr_pkg::KIND_REG
    |=> out_set_vid && out_vid == $past(head.meta.evid))
    else $error("hybrid vid rewrite wrong");
  a_hyb_pri: assert property ( // [RULE_12]
    load && ctl[1:0] == 2'b10 && ctl[2] && ctl[3] && !head.meta.untag
    && head.meta.kind == setr_pkg::KIND_REG
    |=> out_set_pri && out_pri == $past(head.meta.epri))
    else $error("hybrid pri rewrite wrong");
  a_chtag_gate: assert property ( // [RULE_13]
    load && ctl[1:0] == 2'b10 && !ctl[2] && !head.meta.untag
    && head.meta.kind == setr_pkg::KIND_REG
    |=> out_action == 3'(setr_pkg::ACT_PASS)) else $error("change tag gate ignored");
  a_pace_load: assert property (load && paced // [RULE_07] [RULE_08]
    |=> tmr_reg[$past(pidx)] == pace_cycles($past(cur_rate)) - 16'h0001)
    else $error("pacing interval wrong");
  a_pace_gap: assert property (load && paced // [RULE_14]
    |=> !(load && paced && pidx == $past(pidx))) else $error("queue sent too soon");
  a_bus_answer: assert property (req && avs_waitrequest |=> !req || !avs_waitrequest)
    else $error("bus wait too long");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output byte dropped");

  c_insert: cover property (load && dec.act == setr_pkg::ACT_INSERT);
  c_fifo_full: cover property (level == LVL_W'(FIFO_DEPTH));
  c_pace_stall: cover property (s_out.valid && !gate_open);
  c_bus_write: cover property (wr_en && avs_address == reg_addr(setr_pkg::IDX_POLICY));
endmodule
`default_nettype wire

// *** tb/setr_tx_model.sv ***
// Model of the port transmit paths that take paced bytes from the egress stage.
`timescale 1ns/1ps
`default_nettype none
module setr_tx_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic srst,
  // Stall controls from the bench.
  input  wire logic hold,
  input  wire logic rnd,
  // Byte handshake.
  input  wire logic out_valid,
  output logic      out_ready
);
  logic [15:0] lfsr_reg;
  // A real transmit path pauses at will, so ready toggles from a free LFSR when asked.
  // An idle path keeps ready up, so a fresh byte is not always made to wait.
  always_ff @(posedge clk) begin
    if (srst) begin
      lfsr_reg  <= 16'hace1;
      out_ready <= 1'b0;
    end else begin
      lfsr_reg  <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      out_ready <= hold ? 1'b0 : (rnd ? (lfsr_reg[0] | !out_valid) : 1'b1);
    end
  end
endmodule
`default_nettype wire

// *** tb/setr_egress_tb_top.sv ***
// Self-checking bench for the egress tagging and pacing stage.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %0s exp %h got %h", nm, e, g); end end
module setr_egress_tb_top;
  logic clk = 0, srst = 1, avs_read = 0, avs_write = 0, in_valid = 0, in_sop = 0, in_eop = 0;
  logic [17:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, pol = 0, rd;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [7:0]  in_data = 0;
  logic [1:0]  in_egress_port = 0, in_queue = 0, in_src_port = 0, in_tag_kind = 0;
  logic        in_untag = 0, pace_on = 0, hold = 0, rnd = 0;
  logic [11:0] in_ingr_vid = 0, in_egr_vid = 0;
  logic [2:0]  in_ingr_pri = 0, in_egr_pri = 0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, in_ready, out_valid, out_ready, out_sop, out_eop;
  wire         out_set_vid, out_set_pri;
  wire  [7:0]  out_data;
  wire  [1:0]  out_port, out_src_port;
  wire  [2:0]  out_action, out_pri;
  wire  [11:0] out_vid;
  int          miscompares = 0, cmp_count = 0, cyc = 0, n, g;
  integer      seed = 32'h7861889e;
  setr_pkg::setr_dec_s exq[$];
  logic [11:0] exd[$];
  int          tq[$];
  logic [15:0] ra[5] = '{16'h1c0c, 16'h1c0d, 16'h1c0e, 16'h1c0f, 16'h1c10};
  logic [31:0] rm[5] = '{32'h003f_3f3f, 32'h03ff_ffff, 32'h03ff_ffff, 32'h03ff_ffff, 32'h03ff_ffff};

  setr_egress #(.RATE_UNIT_CYC(2), .FIFO_DEPTH(8)) dut (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_sop(in_sop),
    .in_eop(in_eop), .in_egress_port(in_egress_port), .in_queue(in_queue),
    .in_src_port(in_src_port), .in_tag_kind(in_tag_kind), .in_untag(in_untag),
    .in_ingr_vid(in_ingr_vid), .in_ingr_pri(in_ingr_pri), .in_egr_vid(in_egr_vid),
    .in_egr_pri(in_egr_pri), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_sop(out_sop), .out_eop(out_eop), .out_port(out_port),
    .out_action(out_action), .out_set_vid(out_set_vid), .out_set_pri(out_set_pri),
    .out_vid(out_vid), .out_pri(out_pri), .out_src_port(out_src_port));
  setr_tx_model tx (.clk(clk), .srst(srst), .hold(hold), .rnd(rnd),
    .out_valid(out_valid), .out_ready(out_ready));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // Expected tag edit order for one byte, worked out from the policy bits of its egress port.
  function automatic setr_pkg::setr_dec_s exp_dec(logic [31:0] p, logic [1:0] port,
      logic [1:0] k, logic ut, logic [11:0] iv, logic [2:0] ip, logic [11:0] ev, logic [2:0] ep);
    setr_pkg::setr_dec_s d;
    logic [5:0] f;
    f = p >> (port * 8);
    d = '0;
    d.act = setr_pkg::ACT_PASS;
    case (f[1:0])
      2'b00: if (k == 2'd3) d.act = setr_pkg::ACT_STRIP;
      2'b01: if (k != 2'd0) d.act = setr_pkg::ACT_STRIP;
      2'b11: d.act = setr_pkg::ACT_SPECIAL;
      default: begin
        if (k == 2'd3 || (k != 2'd0 && ut)) d.act = setr_pkg::ACT_STRIP;
        else if (k == 2'd0) begin
          if (f[5] && !ut) d = '{setr_pkg::ACT_INSERT, 1'b1, 1'b1, iv, ip};
        end else if (k == 2'd1) d = '{setr_pkg::ACT_REWRITE, 1'b1, f[3], iv, ep};
        else if (f[2] && (f[4] || f[3])) d = '{setr_pkg::ACT_REWRITE, f[4], f[3], ev, ep};
      end
    endcase
    return d;
  endfunction

  // One register access; the request holds until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    avs_address   <= {idx, 2'b00};
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= wd;
    n = 0;
    do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) miscompares++;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  // One single-byte packet with random sideband; the expectation is queued when it is taken.
  task automatic send(input logic [1:0] port, input logic [1:0] q, input logic [1:0] k);
    logic [1:0] s;
    logic [7:0] d;
    s = $unsigned($random(seed)) % 3;
    d = $random(seed);
    {in_valid, in_sop, in_eop, in_egress_port, in_queue, in_tag_kind} <= {3'b111, port, q, k};
    {in_src_port, in_data, in_untag} <= {s, d, 1'($random(seed))};
    {in_ingr_vid, in_ingr_pri, in_egr_vid, in_egr_pri} <= 30'($random(seed));
    n = 0;
    do begin @(posedge clk); n++; end while (in_ready !== 1'b1 && n < 100);
    if (n >= 100) miscompares++;
    exq.push_back(exp_dec(pol, port, k, in_untag, in_ingr_vid, in_ingr_pri, in_egr_vid,
                          in_egr_pri));
    exd.push_back({s, port, d});
  endtask

  // Waits, under a bound, until every expected byte has left.
  task automatic drain();
    n = 0;
    while (exq.size() != 0 && n < 4000) begin @(posedge clk); n++; end
    `CHK("drained", 1'b1, exq.size() == 0);
  endtask

  // Sends five bytes to one queue and checks the spacing of their departures.
  task automatic pace(input logic [1:0] port, input logic [1:0] q, input int gap);
    tq.delete();
    pace_on <= 1'b1;
    repeat (5) send(port, q, 2'd0);
    in_valid <= 1'b0;
    drain();
    pace_on <= 1'b0;
    for (int i = 1; i < tq.size(); i++) begin
      g = tq[i] - tq[i-1];
      `CHK("byte gap", 1'b1, port == 2 ? g == 1 : (g >= gap && g <= gap + 2));
    end
  endtask

  // Output monitor: every byte the transmit path takes is compared with the head expectation.
  always @(posedge clk) begin
    setr_pkg::setr_dec_s e;
    logic [11:0] dd;
    cyc <= cyc + 1;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (pace_on) tq.push_back(cyc);
      if (exq.size() == 0) `CHK("spare byte", 1'b0, 1'b1);
      if (exq.size() != 0) begin
        e = exq.pop_front();
        dd = exd.pop_front();
        `CHK("port and data", dd[9:0], {out_port, out_data});
        `CHK("packet marks", 2'b11, {out_sop, out_eop});
        `CHK("action", e.act, out_action);
        if (e.act == setr_pkg::ACT_SPECIAL) `CHK("source", dd[11:10], out_src_port);
        if (e.act == setr_pkg::ACT_INSERT || e.act == setr_pkg::ACT_REWRITE) begin
          `CHK("set flags", {e.set_vid, e.set_pri}, {out_set_vid, out_set_pri});
          if (e.set_vid) `CHK("vid", e.vid, out_vid);
          if (e.set_pri) `CHK("pri", e.pri, out_pri);
        end
      end
    end
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the expected length of all scenarios.
  initial begin
    #400_000;
    miscompares++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0);
      `CHK("reset value", 32'h0000_0000, rd);
      bus(1'b1, ra[i], 32'hffff_ffff);
      bus(1'b0, ra[i], 32'h0);
      `CHK("writable bits", rm[i], rd);
    end
    bus(1'b1, 16'h1c20, 32'hffff_ffff);
    bus(1'b0, 16'h1c20, 32'h0);
    `CHK("unmapped read", 32'h0000_0000, rd);
    // Odd queues sit in the upper field, so distinct values per field expose a swap.
    pol = 32'h0;
    bus(1'b1, 16'h1c0c, pol);
    bus(1'b1, 16'h1c0d, 32'h0000_2004);
    bus(1'b1, 16'h1c0e, 32'h0000_0000);
    bus(1'b1, 16'h1c0f, 32'h0000_0000);
    bus(1'b1, 16'h1c10, 32'h0000_4000);
    pace(2'd0, 2'd0, 10);
    pace(2'd0, 2'd1, 4);
    pace(2'd0, 2'd2, 2);
    pace(2'd1, 2'd3, 6);
    pace(2'd2, 2'd0, 1);
    // Stalled transmit path: FIFO plus output register take nine bytes, then refuse.
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    repeat (9) send(2'd2, 2'd0, 2'd0);
    in_valid <= 1'b0;
    @(posedge clk);
    `CHK("full refuses", 1'b0, in_ready);
    // Full FIFO, loaded output byte, unpaced head: level 8 and output busy.
    bus(1'b0, 16'h1c3f, 32'h0);
    `CHK("status", 32'h0000_0108, rd);
    hold <= 1'b0;
    drain();
    `CHK("empty accepts", 1'b1, in_ready);
    // Random traffic under random stalls; the first half walks every port type.
    rnd <= 1'b1;
    for (int it = 0; it < 24; it++) begin
      pol = $random(seed) & 32'h003f_3f3f;
      if (it < 12) pol = (pol & 32'h003c_3c3c) | ({30'h0, 2'(it % 4)} * 32'h0001_0101);
      bus(1'b1, 16'h1c0c, pol);
      repeat (4) send(2'($unsigned($random(seed)) % 3), 2'($random(seed)), 2'($random(seed)));
      in_valid <= 1'b0;
      drain();
    end
    end_of_test();
  end
endmodule
`default_nettype wire
